// file: include/pseq_defs.svh
`ifndef PSEQ_DEFS_SVH
`define PSEQ_DEFS_SVH
`define A_CTRL 12'h000
`define A_STAT 12'h004
`define A_ODEF 12'h008
`define A_INPS 12'h00c
`define TMR_PG 8'h01
`define EXC_PG 8'h02
`define PRG_PG 4'h1
`define W_INS 2'h0
`define W_CND 2'h1
`define W_OUT 2'h2
`define C_RUN 0
`define C_MST 1
`define C_CP 2
`define ST_STEP 0
`define ST_RUN 4
`define ST_EXP 8
`define ST_OUT 16
`define I_OP 0
`define I_INT 3
`define I_TSEL 4
`define I_TA 8
`define I_TB 12
`define I_TC 16
`define K_MASK 0
`define K_POL 8
`define O_MASK 0
`define O_VAL 8
`define O_EMASK 16
`define O_EVAL 24
`define E_MASK 0
`define E_POL 8
`define E_HND 16
`define E_OIDX 20
`define E_OEN 23
`define E_INV 24
`define E_EN 25
`define W_STEP 4
`define W_IO 8
`define W_TSEL 2
`define W_TCNT 16
`define W_OIDX 3
`define N_CFG 4
`define N_EXC 2
`define HV_BIT 0
`define CLK_NS 100
`define TICK_NS 32000
`define TICK_CYC (`TICK_NS / `CLK_NS)
`define CP_HI_NS 32000
`define CP_LO_NS 8000
`define CP_HI_CYC (`CP_HI_NS / `CLK_NS)
`define CP_PER_CYC ((`CP_HI_NS + `CP_LO_NS) / `CLK_NS)
`define OUT_RST 8'h00
`define TDLY_RST 16'h0001
`define CTRL_RST 3'h0
`endif

// file: include/pseq_pkg.sv
`include "pseq_defs.svh"
package pseq_pkg;
	typedef logic [`W_STEP-1:0] step_t;
	typedef enum logic [2:0] {
		OP_WAIT_TMR  = 3'b000,
		OP_WAIT_COND = 3'b001,
		OP_WAIT_TO   = 3'b010,
		OP_IF        = 3'b011,
		OP_IF_TMR    = 3'b100,
		OP_OUT       = 3'b101,
		OP_GOTO      = 3'b110,
		OP_HALT      = 3'b111
	} op_t;
endpackage : pseq_pkg

// file: design/pseq_engine.sv
// Implementation choices: the register offsets and the APB register port.
`timescale 1ns/1ps
`include "pseq_defs.svh"
module pseq_engine #(
	parameter int N_TMR = 4
) (
	// Clock and reset
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	// APB slave
	input  wire logic [11:0]          paddr,
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [31:0]          pwdata,
	output logic                      pready,
	output logic                      pslverr,
	output logic [31:0]               prdata,
	// Monitor comparators and digital inputs
	input  wire logic [`W_IO-1:0]     cond_in,
	// Timer tick sharing between devices
	input  wire logic                 tick_in,
	output logic                      tick_out,
	// Supply enables, resets and gate drives
	output logic [`W_IO-1:0]          ctrl_out,
	output logic                      high_voltage_gate_drive,
	output logic                      charge_pump_gate_drive,
	output pseq_pkg::step_t           seq_step
);
	import pseq_pkg::*;

	localparam int NSTEP = 1 << `W_STEP;
	localparam int CPHI = `CP_HI_CYC;

	function automatic logic expr(input logic [`W_IO-1:0] m, p, x);
		return &(~m | ~(x ^ p));
	endfunction : expr

	////////////////////////////////////////////////////////////////////////////
	logic [2:0]             ctrl_ff;
	logic [`W_IO-1:0]       odef_ff;
	logic [`W_TCNT-1:0]     tdly_ff [N_TMR];
	logic [31:0]            ecfg_ff [`N_CFG];
	logic [31:0]            ins_mem [NSTEP];
	logic [31:0]            cnd_mem [NSTEP];
	logic [31:0]            out_mem [NSTEP];
	logic [31:0]            prdata_ff;
	logic [31:0]            rd;
	logic [31:0]            st;
	step_t                  step_ff;
	step_t                  nxt_step;
	logic                   first_ff;
	logic [`W_IO-1:0]       seq_ff;
	logic [`W_IO-1:0]       nxt_seq;
	logic [`W_IO-1:0]       out_ff;
	logic [`W_IO-1:0]       nxt_out;
	logic [`W_IO-1:0]       own;
	logic [`W_IO-1:0]       ov;
	logic [`W_TCNT-1:0]     tcnt_ff [N_TMR];
	logic [N_TMR-1:0]       texp_ff;
	logic [`W_TCNT-1:0]     pre_ff;
	logic                   tick_ff;
	logic [`W_TCNT-1:0]     cp_cnt_ff;
	logic                   cp_ff;
	logic [`N_EXC-1:0]      eprev_ff;
	logic [`N_CFG-1:0]      e_true;
	logic                   adv;
	logic                   path_else;

	////////////////////////////////////////////////////////////////////////////
	wire        setup = psel & ~penable;
	wire        acc   = psel & penable;
	wire        wr    = acc & pwrite;
	wire        pg_t  = paddr[11:4] == `TMR_PG;
	wire        pg_e  = paddr[11:4] == `EXC_PG;
	wire        pg_p  = paddr[11:8] == `PRG_PG;
	wire [1:0]  pidx  = paddr[3:2];
	wire step_t pstep = paddr[7:4];
	wire        t_ok  = pg_t & (32'(pidx) < N_TMR);
	wire        p_ok  = pg_p & (pidx <= `W_OUT);
	wire        hit   = (paddr[1:0] == 2'h0) & (paddr == `A_CTRL | paddr == `A_STAT |
				paddr == `A_ODEF | paddr == `A_INPS | t_ok | pg_e | p_ok);
	assign pready  = 1'b1;
	assign pslverr = acc & ~hit;
	assign prdata  = prdata_ff;

	always_comb begin
		st = 32'h0;
		st[`ST_STEP +: `W_STEP] = step_ff;
		st[`ST_RUN] = ctrl_ff[`C_RUN];
		st[`ST_EXP +: N_TMR] = texp_ff;
		st[`ST_OUT +: `W_IO] = out_ff;
	end

	always_comb begin
		rd = 32'h0;
		if (paddr == `A_CTRL)
			rd[2:0] = ctrl_ff;
		else if (paddr == `A_STAT)
			rd = st;
		else if (paddr == `A_ODEF)
			rd[`W_IO-1:0] = odef_ff;
		else if (paddr == `A_INPS)
			rd[`W_IO-1:0] = cond_in;
		else if (t_ok)
			rd[`W_TCNT-1:0] = tdly_ff[pidx];
		else if (pg_e)
			rd = ecfg_ff[pidx];
		else if (p_ok)
			rd = (pidx == `W_INS) ? ins_mem[pstep] :
			     (pidx == `W_CND) ? cnd_mem[pstep] : out_mem[pstep];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prdata_ff <= 32'h0;
		else if (setup)
			prdata_ff <= rd;
	end

	// Configuration and program store. The program may be rewritten while running;
	// software should clear run first, as a half-written step would execute.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_ff <= `CTRL_RST;
			odef_ff <= `OUT_RST;
			for (int i = 0; i < N_TMR; i++)
				tdly_ff[i] <= `TDLY_RST;
			for (int i = 0; i < `N_CFG; i++)
				ecfg_ff[i] <= 32'h0;
			for (int i = 0; i < NSTEP; i++) begin
				ins_mem[i] <= 32'h0;
				cnd_mem[i] <= 32'h0;
				out_mem[i] <= 32'h0;
			end
		end else if (wr & hit) begin
			if (paddr == `A_CTRL)
				ctrl_ff <= pwdata[2:0];
			if (paddr == `A_ODEF)
				odef_ff <= pwdata[`W_IO-1:0];
			if (t_ok)
				tdly_ff[pidx] <= pwdata[`W_TCNT-1:0];
			if (pg_e)
				ecfg_ff[pidx] <= pwdata;
			if (p_ok && pidx == `W_INS)
				ins_mem[pstep] <= pwdata;
			if (p_ok && pidx == `W_CND)
				cnd_mem[pstep] <= pwdata;
			if (p_ok && pidx == `W_OUT)
				out_mem[pstep] <= pwdata;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	wire [31:0] ins   = ins_mem[step_ff];
	wire [31:0] cnd   = cnd_mem[step_ff];
	wire [31:0] ow    = out_mem[step_ff];
	wire op_t   op    = op_t'(ins[`I_OP +: 3]);
	wire        intr  = ins[`I_INT];
	wire [1:0]  tsel  = ins[`I_TSEL +: `W_TSEL];
	wire step_t ta    = ins[`I_TA +: `W_STEP];
	wire step_t tb    = ins[`I_TB +: `W_STEP];
	wire step_t tc    = ins[`I_TC +: `W_STEP];
	wire step_t s_inc = step_t'(step_ff + 4'h1);
	wire        run   = ctrl_ff[`C_RUN];
	wire        cond  = expr(cnd[`K_MASK +: `W_IO], cnd[`K_POL +: `W_IO], cond_in);
	wire        texp  = texp_ff[tsel];
	wire [`N_EXC-1:0] e_rise = e_true[`N_EXC-1:0] & ~eprev_ff;
	// Edge sensitive so that a handler step marked interruptible is not re-entered
	// every cycle while the fault persists.
	wire        exc_take = run & intr & (|e_rise);
	wire step_t exc_tgt  = e_rise[0] ? ecfg_ff[0][`E_HND +: `W_STEP] :
	                                   ecfg_ff[1][`E_HND +: `W_STEP];
	wire [31:0] nins  = ins_mem[nxt_step];
	wire op_t   nop   = op_t'(nins[`I_OP +: 3]);
	wire        nuset = (nop == OP_WAIT_TMR) | (nop == OP_WAIT_TO);
	wire        enter = run & (adv | exc_take);

	genvar g;
	generate
		for (g = 0; g < `N_CFG; g++) begin : g_eq
			assign e_true[g] = ecfg_ff[g][`E_EN] & expr(ecfg_ff[g][`E_MASK +: `W_IO],
			                   ecfg_ff[g][`E_POL +: `W_IO], cond_in);
		end
	endgenerate

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			eprev_ff <= '0;
		else
			eprev_ff <= e_true[`N_EXC-1:0];
	end

	always_comb begin
		nxt_step  = step_ff;
		adv       = 1'b0;
		path_else = 1'b0;
		case (op)
			OP_WAIT_TMR: begin
				adv = texp;
				nxt_step = texp ? s_inc : step_ff;
			end
			OP_WAIT_COND: begin
				adv = cond;
				nxt_step = cond ? s_inc : step_ff;
			end
			OP_WAIT_TO: begin
				adv = cond | texp;
				nxt_step = cond ? s_inc : (texp ? tc : step_ff);
			end
			OP_IF: begin
				adv = 1'b1;
				path_else = ~cond;
				nxt_step = cond ? ta : tb;
			end
			OP_IF_TMR: begin
				adv = 1'b1;
				path_else = ~cond;
				nxt_step = cond ? ta : (texp ? tc : tb);
			end
			OP_OUT: begin
				adv = 1'b1;
				nxt_step = s_inc;
			end
			OP_GOTO: begin
				adv = 1'b1;
				nxt_step = ta;
			end
			OP_HALT: nxt_step = step_ff;
			default: nxt_step = step_ff;
		endcase
		if (exc_take)
			nxt_step = exc_tgt;
		if (!run)
			nxt_step = '0;
	end

	// Step outputs land once, at the edge closing the first cycle in the step.
	wire [`W_IO-1:0] om = path_else ? ow[`O_EMASK +: `W_IO] : ow[`O_MASK +: `W_IO];
	wire [`W_IO-1:0] vm = path_else ? ow[`O_EVAL +: `W_IO] : ow[`O_VAL +: `W_IO];
	always_comb begin
		nxt_seq = seq_ff;
		if (!run)
			nxt_seq = odef_ff;
		else if (first_ff)
			nxt_seq = (seq_ff & ~om) | (vm & om);
	end

	// Later entries are overridden by earlier ones, so exceptions win over equations.
	always_comb begin
		own = '0;
		ov  = '0;
		for (int i = `N_CFG - 1; i >= 0; i--) begin
			if (ecfg_ff[i][`E_EN] && ecfg_ff[i][`E_OEN]) begin
				own[ecfg_ff[i][`E_OIDX +: `W_OIDX]] = 1'b1;
				ov[ecfg_ff[i][`E_OIDX +: `W_OIDX]]  = e_true[i] ^ ecfg_ff[i][`E_INV];
			end
		end
		nxt_out = (nxt_seq & ~own) | (ov & own);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			step_ff  <= '0;
			first_ff <= 1'b1;
			seq_ff   <= `OUT_RST;
			out_ff   <= `OUT_RST;
		end else begin
			step_ff  <= nxt_step;
			first_ff <= enter | ~run;
			seq_ff   <= nxt_seq;
			out_ff   <= nxt_out;
		end
	end

	assign seq_step = step_ff;
	assign ctrl_out = out_ff;
	assign high_voltage_gate_drive = out_ff[`HV_BIT];

	////////////////////////////////////////////////////////////////////////////
	wire mtick = pre_ff == `W_TCNT'(`TICK_CYC - 1);
	wire tick  = ctrl_ff[`C_MST] ? tick_ff : tick_in;
	assign tick_out = tick_ff;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pre_ff  <= '0;
			tick_ff <= 1'b0;
		end else begin
			pre_ff  <= mtick ? '0 : pre_ff + 1'b1;
			tick_ff <= mtick & ctrl_ff[`C_MST];
		end
	end

	generate
		for (g = 0; g < N_TMR; g++) begin : g_tmr
			wire t_run = run & ((op == OP_WAIT_TMR) | (op == OP_WAIT_TO)) &
			             (32'(tsel) == g);
			wire t_clr = ~run | (enter & nuset & (32'(nins[`I_TSEL +: `W_TSEL]) == g));
			wire [`W_TCNT-1:0] t_inc = tcnt_ff[g] + 1'b1;
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					tcnt_ff[g] <= '0;
					texp_ff[g] <= 1'b0;
				end else if (t_clr) begin
					tcnt_ff[g] <= '0;
					texp_ff[g] <= 1'b0;
				end else if (t_run && tick && !texp_ff[g]) begin
					tcnt_ff[g] <= t_inc;
					texp_ff[g] <= t_inc >= tdly_ff[g];
				end
			end
		end
	endgenerate

	// Free running so the pump never stops mid pulse on a sequencer change.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cp_cnt_ff <= '0;
			cp_ff     <= 1'b0;
		end else begin
			cp_cnt_ff <= (cp_cnt_ff == `W_TCNT'(`CP_PER_CYC - 1)) ? '0 : cp_cnt_ff + 1'b1;
			cp_ff     <= ctrl_ff[`C_CP] & (cp_cnt_ff < `W_TCNT'(`CP_HI_CYC));
		end
	end
	assign charge_pump_gate_drive = cp_ff;

	////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_out_apply: assert property (run && first_ff && op == OP_OUT |=>
		(out_ff & $past(om) & ~$past(own)) == ($past(vm) & $past(om) & ~$past(own)))
		else $error("output step value not applied");
	a_halt_stay: assert property (run && op == OP_HALT && !exc_take |=>
		$stable(step_ff) && !first_ff)
		else $error("halt left its step");
	a_goto_dest: assert property (run && op == OP_GOTO && !exc_take |=>
		step_ff == $past(ta) && first_ff)
		else $error("goto missed its target");
	a_wait_hold: assert property (run && op == OP_WAIT_COND && !cond && !exc_take |=>
		$stable(step_ff))
		else $error("condition wait advanced early");
	a_if_path: assert property (run && op == OP_IF_TMR && !exc_take |=>
		step_ff == ($past(cond) ? $past(ta) : ($past(texp) ? $past(tc) : $past(tb))))
		else $error("timed branch took wrong path");
	a_no_intr: assert property (run && !intr && (|e_rise) && op == OP_WAIT_COND && !cond |=>
		$stable(step_ff))
		else $error("non-interruptible step redirected");
	a_exc_jump: assert property (exc_take && run |=> step_ff == $past(exc_tgt))
		else $error("exception did not reach handler");
	a_tmr_wait: assert property (run && op == OP_WAIT_TMR && !texp && !exc_take |=>
		$stable(step_ff))
		else $error("timer wait left before expiry");
	a_exc_out: assert property (ecfg_ff[0][`E_EN] && ecfg_ff[0][`E_OEN] |=>
		out_ff[$past(ecfg_ff[0][`E_OIDX +: `W_OIDX])] == $past(e_true[0] ^ ecfg_ff[0][`E_INV]))
		else $error("exception output not following expression");
	a_cp_high: assert property ($fell(cp_ff) && $past(ctrl_ff[`C_CP]) |->
		cp_cnt_ff == `W_TCNT'(CPHI + 1))
		else $error("charge pump high phase wrong length");
	a_stop_home: assert property (!run |=> step_ff == '0 && out_ff == $past(nxt_out))
		else $error("stopped sequencer not at step zero");

	c_halt: cover property (run && op == OP_HALT);
	c_exc: cover property (exc_take);
	c_timeout: cover property (run && op == OP_WAIT_TO && !cond && texp);
	c_cp: cover property ($fell(cp_ff));
endmodule : pseq_engine

// file: dv/pseq_monitor_model.sv
`timescale 1ns/1ps
module pseq_monitor_model (
	// Clock and reset
	input  wire logic       pclk,
	input  wire logic       presetn,
	// Rail enable and board pins
	input  wire logic       rail_en,
	input  wire logic       slow,
	input  wire logic [7:1] dig_in,
	// Comparator outputs and slave tick
	output logic [7:0]      cond_in,
	output logic            tick_in
);
	// A rail reports good only after its ramp, so the engine must really wait.
	logic [8:0] ramp_ff;
	logic [8:0] tcnt_ff;
	assign cond_in = {dig_in, ramp_ff >= (slow ? 9'h028 : 9'h003)};
	assign tick_in = (tcnt_ff == 9'h13f);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ramp_ff <= 9'h000;
			tcnt_ff <= 9'h000;
		end else begin
			ramp_ff <= rail_en ? ramp_ff + {8'h00, ramp_ff < 9'h028} : 9'h000;
			tcnt_ff <= tick_in ? 9'h000 : tcnt_ff + 9'h001;
		end
	end
endmodule : pseq_monitor_model

// file: dv/pseq_engine_tb_top.sv
`timescale 1ns/1ps
`include "pseq_defs.svh"
module pseq_engine_tb_top;
	import pseq_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic        tick_in, tick_out, hv, cp, slow, t, p;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [7:1]  dig_in;
	logic [7:0]  cond_in, ctrl_out, ce;
	step_t       seq_step;
	int          error_cnt, tests_run, cyc, n;
	////////////////////////////////////////////////////////////////
	pseq_engine pseq_engine_i (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready),
		.pslverr(pslverr), .prdata(prdata), .cond_in(cond_in), .tick_in(tick_in),
		.tick_out(tick_out), .ctrl_out(ctrl_out), .high_voltage_gate_drive(hv),
		.charge_pump_gate_drive(cp), .seq_step(seq_step));
	pseq_monitor_model pseq_monitor_model_i (.pclk(pclk), .presetn(presetn),
		.rail_en(ctrl_out[1]), .slow(slow), .dig_in(dig_in), .cond_in(cond_in),
		.tick_in(tick_in));
	////////////////////////////////////////////////////////////////
	initial pclk = 1'b0;
	always #50 pclk = ~pclk;
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 60000) begin
			error_cnt++;
			report_and_stop();
		end
	end
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : report_and_stop
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	// Request is held until pready is seen high, as the bus demands.
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wait_step(input step_t s, input int mx);
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (seq_step !== s && n < mx);
		chk("seq_step", {28'h0, s}, {28'h0, seq_step});
	endtask : wait_step
	function automatic logic [31:0] ins(op_t o, logic i, logic [3:0] th, logic [3:0] el);
		return {16'h0000, el, th, 4'h0, i, o};
	endfunction : ins
	////////////////////////////////////////////////////////////////
	initial begin
		{presetn, psel, penable, pwrite, slow, paddr, pwdata, dig_in} = '0;
		error_cnt = 0;
		tests_run = 0;
		cyc = 0;
		void'($urandom(32'hff74));
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, 12'h004, 32'h0);
		chk("status_rst", 32'h0, rd);
		apb(1'b0, 12'h010, 32'h0);
		chk("delay_rst", 32'h1, rd);
		apb(1'b0, 12'hffc, 32'h0);
		chk("unmapped", 32'h1, rd | {31'h0, err});
		apb(1'b1, 12'h014, 32'hffff);
		apb(1'b0, 12'h014, 32'h0);
		chk("delay_max", 32'hffff, rd);
		apb(1'b1, 12'h010, 32'h2);
		apb(1'b1, 12'h020, 32'h02d8_2020);
		apb(1'b1, 12'h028, 32'h03e0_0010);
		apb(1'b1, 12'h100, ins(OP_OUT, 1'b0, 4'h0, 4'h0));
		apb(1'b1, 12'h108, 32'h0303);
		apb(1'b1, 12'h110, ins(OP_WAIT_COND, 1'b0, 4'h0, 4'h0));
		apb(1'b1, 12'h114, 32'h0101);
		apb(1'b1, 12'h120, ins(OP_WAIT_TMR, 1'b0, 4'h0, 4'h0));
		apb(1'b1, 12'h130, ins(OP_IF, 1'b0, 4'h4, 4'h5));
		apb(1'b1, 12'h138, 32'h0808_0404);
		apb(1'b1, 12'h140, ins(OP_GOTO, 1'b0, 4'h6, 4'h0));
		apb(1'b1, 12'h150, ins(OP_GOTO, 1'b0, 4'h6, 4'h0));
		apb(1'b1, 12'h160, ins(OP_WAIT_COND, 1'b0, 4'h0, 4'h0));
		apb(1'b1, 12'h164, 32'h4040);
		apb(1'b1, 12'h170, ins(OP_HALT, 1'b1, 4'h0, 4'h0));
		apb(1'b1, 12'h180, ins(OP_WAIT_TO, 1'b0, 4'h0, 4'h0) | 32'h0009_0000);
		apb(1'b1, 12'h184, 32'h0040);
		apb(1'b1, 12'h190, ins(OP_IF_TMR, 1'b0, 4'h7, 4'h7) | 32'h000a_0000);
		apb(1'b1, 12'h194, 32'h0040);
		apb(1'b1, 12'h1a0, ins(OP_HALT, 1'b0, 4'h0, 4'h0));
		// Odd passes use the slave tick and a slow rail.
		for (int it = 0; it < 3; it++) begin
			p = 1'($urandom);
			t = 1'($urandom);
			slow <= it[0];
			dig_in <= {p ^ ~t, 2'b00, 4'($urandom)};
			apb(1'b1, 12'h134, {16'h0, p, 7'h0, 8'h80});
			apb(1'b1, 12'h000, {30'h0, ~it[0], 1'b1});
			wait_step(4'h1, 5);
			chk("out_step0", 32'h3, {30'h0, ctrl_out[1:0]});
			chk("hv_drive", 32'h1, {31'h0, hv});
			repeat (4) @(posedge pclk);
			chk("cond_hold", {31'h0, it[0]}, {31'h0, seq_step == 4'h1});
			wait_step(4'h2, 60);
			wait_step(4'h3, 700);
			chk("tmr_wait", 32'h1, {31'h0, n >= 320 && n <= 642});
			wait_step(t ? 4'h4 : 4'h5, 1);
			chk("if_out", {30'h0, ~t, t}, {30'h0, ctrl_out[3:2]});
			wait_step(4'h6, 1);
			dig_in[5] <= 1'b1;
			repeat (3) @(posedge pclk);
			chk("no_exc", 32'h6, {28'h0, seq_step});
			chk("exc_out", 32'h1, {31'h0, ctrl_out[5]});
			dig_in[6] <= 1'b1;
			wait_step(4'h7, 3);
			dig_in[5] <= 1'b0;
			repeat (20) @(posedge pclk);
			chk("halt", 32'h7, {28'h0, seq_step});
			chk("exc_low", 32'h0, {31'h0, ctrl_out[5]});
			dig_in[5] <= 1'b1;
			wait_step(4'h8, 4);
			for (int k = 0; k < 6; k++) begin
				dig_in[4] <= 1'($urandom);
				repeat (3) @(posedge pclk);
				chk("sup_out", {31'h0, dig_in[4]}, {31'h0, ctrl_out[6]});
			end
			ce = {1'b0, dig_in[4], 2'b10, ~t, t, 2'b11};
			apb(1'b0, 12'h004, 32'h0);
			chk("status", {8'h0, ce, 16'h0018}, rd & 32'h00ff_001f);
			wait_step(4'h9, 700);
			wait_step(4'ha, 1);
			apb(1'b1, 12'h000, 32'h0);
			dig_in <= '0;
			repeat (3) @(posedge pclk);
			chk("stopped", 32'h0, {20'h0, ctrl_out, seq_step});
			$display("test %0d done", it);
		end
		apb(1'b1, 12'h000, 32'h6);
		do @(posedge pclk); while (tick_out !== 1'b1);
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (tick_out !== 1'b1);
		chk("tick_period", `TICK_CYC, n);
		// Start from a real rising edge so a phase cut by the enable is not measured.
		do @(posedge pclk); while (cp !== 1'b0);
		do @(posedge pclk); while (cp !== 1'b1);
		n = 0;
		while (cp === 1'b1) begin
			@(posedge pclk);
			n++;
		end
		chk("cp_high", `CP_HI_CYC, n);
		n = 0;
		while (cp === 1'b0) begin
			@(posedge pclk);
			n++;
		end
		chk("cp_low", `CP_PER_CYC - `CP_HI_CYC, n);
		$display("test charge pump done");
		report_and_stop();
	end
endmodule : pseq_engine_tb_top
